// [design/mult_interlock_regs.vh]
// Constants for the multiplier contention interlock: instruction class codes,
// sequencer state codes, multiplier busy counts and the gap threshold.
// Assumes the decoder supplies a 4-bit class code for each instruction.
`ifndef MULT_INTERLOCK_REGS_VH
`define MULT_INTERLOCK_REGS_VH

// ----------------------------------------------------------------------------
// Instruction class codes
// ----------------------------------------------------------------------------
`define CLASS_W                         4
`define CLASS_OTHER                     4'h0
`define CLASS_SIGNED_WORD_MULTIPLY      4'h1
`define CLASS_SIGNED_DOUBLE_LENGTH      4'h2
`define CLASS_UNSIGNED_DOUBLE_LENGTH    4'h3
`define CLASS_LONG_PRODUCT_MULTIPLY     4'h4
`define CLASS_LONG_MULTIPLY_ACCUMULATE  4'h5
`define CLASS_WORD_MULTIPLY_ACCUMULATE  4'h6
`define CLASS_ACC_STORE_TO_REGISTER     4'h7
`define CLASS_ACC_STORE_TO_MEMORY       4'h8
`define CLASS_ACC_LOAD_FROM_REGISTER    4'h9
`define CLASS_ACC_LOAD_FROM_MEMORY      4'hA

// ----------------------------------------------------------------------------
// Memory access sequencer states, one-hot
// ----------------------------------------------------------------------------
`define SEQ_W                           4
`define SEQ_IDLE                        4'h1
`define SEQ_MEM                         4'h2
`define SEQ_FIRST                       4'h4
`define SEQ_MULT                        4'h8

// ----------------------------------------------------------------------------
// Multiplier busy counts, in multiplier busy cycles
// ----------------------------------------------------------------------------
`define BUSY_W                          3
`define BUSY_NONE                       3'h0
`define BUSY_WORD                       3'h2
`define BUSY_DOUBLE_LENGTH              3'h4
`define BUSY_LONG_MAC                   3'h4
`define BUSY_WORD_MAC                   3'h2

// ----------------------------------------------------------------------------
// Unrelated instructions that saturate the gap count
// ----------------------------------------------------------------------------
`define GAP_W                           2
`define GAP_CLEAR                       2'h2

`endif

// [design/multiplier_busy_counter.v]
// Multiplier busy down-counter.
// Assumes load and the count come from the interlock sequencer in the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "mult_interlock_regs.vh"

module multiplier_busy_counter (
    input  wire                mclk,
    input  wire                rstn,
    input  wire                load,
    input  wire [`BUSY_W-1:0]  load_value,
    output reg  [`BUSY_W-1:0]  count,
    output wire                busy
);

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    // Load wins over the decrement so a back-to-back multiply is not lost
    always @(posedge mclk) begin
        if (!rstn) begin
            count <= `BUSY_NONE;
        end else if (load) begin
            count <= load_value;
        end else if (count != `BUSY_NONE) begin
            count <= count - 3'h1;
        end
    end

    assign busy = (count != `BUSY_NONE);

endmodule
`default_nettype wire

// [design/multiplier_contention_interlock.v]
// Interlock for the shared multiplier: decode hold, memory access sequencing,
// multiplier access stretching and fetch-versus-access slot splitting.
// Assumes the decoder presents one instruction class per cycle on id_valid
// and the fetch unit raises if_request until it is granted.
//
// Summary of operation
// - Accumulator store to memory gets a multiplier-read, memory-write stage contending fetch.
// - Accumulator load from register after word multiply gets a multiplier write stage.
// - That stage stretches while the multiplier runs and counts as one slot.
// - The register-load multiplier stage contends with fetch; the slot splits.
// - Accumulator load from memory gets a stretched, fetch-contending multiplier stage.
// - Signed, unsigned double-length and long product multiplies share one timing.
// - Double-length second access feeds the multiplier, busy four cycles afterwards.
// - Decode of the instruction after a double-length multiply holds one slot.
// - Either double-length access stage splits the slot with a fetch.
// - Unrelated instruction after double-length multiply sees a plain five-stage pipe.
// - Multiplier users right after a double-length multiply are detected as contention.
// - A multiplier user resets the gap count when decoded, so its contention stall lasts until the busy count runs out.
`timescale 1ns/1ps
`default_nettype none
`include "mult_interlock_regs.vh"

module multiplier_contention_interlock (
    input  wire                 mclk,
    input  wire                 rstn,
    input  wire                 id_valid,
    input  wire [`CLASS_W-1:0]  id_class,
    input  wire                 id_memory,
    input  wire                 if_request,
    output reg                  id_hold,
    output reg                  ma_bus_grant,
    output reg                  if_bus_grant,
    output reg                  slot_split,
    output reg                  ma_stretch,
    output reg                  mult_start,
    output reg                  mult_busy,
    output reg                  mult_contention
);

    // ------------------------------------------------------------------------
    // Class decode
    // ------------------------------------------------------------------------
    function is_double_length;
        input [`CLASS_W-1:0] c;
        begin
            is_double_length = (c == `CLASS_SIGNED_DOUBLE_LENGTH) ||
                               (c == `CLASS_UNSIGNED_DOUBLE_LENGTH) ||
                               (c == `CLASS_LONG_PRODUCT_MULTIPLY);
        end
    endfunction

    function uses_multiplier;
        input [`CLASS_W-1:0] c;
        begin
            uses_multiplier = (c != `CLASS_OTHER);
        end
    endfunction

    function [`BUSY_W-1:0] busy_after;
        input [`CLASS_W-1:0] c;
        begin
            case (c)
                `CLASS_SIGNED_WORD_MULTIPLY:     busy_after = `BUSY_WORD;
                `CLASS_SIGNED_DOUBLE_LENGTH:     busy_after = `BUSY_DOUBLE_LENGTH;
                `CLASS_UNSIGNED_DOUBLE_LENGTH:   busy_after = `BUSY_DOUBLE_LENGTH;
                `CLASS_LONG_PRODUCT_MULTIPLY:    busy_after = `BUSY_DOUBLE_LENGTH;
                `CLASS_LONG_MULTIPLY_ACCUMULATE: busy_after = `BUSY_LONG_MAC;
                `CLASS_WORD_MULTIPLY_ACCUMULATE: busy_after = `BUSY_WORD_MAC;
                default:                         busy_after = `BUSY_NONE;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg                 ex_valid;
    reg [`CLASS_W-1:0]  ex_class;
    reg                 ex_memory;
    reg [`SEQ_W-1:0]    seq_state;
    reg [`CLASS_W-1:0]  seq_class;
    reg [`GAP_W-1:0]    gap;
    reg                 last_double;
    reg                 last_word;

    reg [`SEQ_W-1:0]    next_seq_state;
    reg [`CLASS_W-1:0]  next_seq_class;
    reg                 next_ex_valid;
    reg                 stage_wait;
    reg                 ma_bus;
    reg                 mult_end;
    reg                 seq_free;

    wire [`BUSY_W-1:0]  busy_count;
    wire                busy_now;
    wire                id_accept;
    wire                ex_move;
    wire                gap_ok;

    assign id_accept = id_valid && !id_hold;
    assign gap_ok    = (gap >= `GAP_CLEAR);

    // ------------------------------------------------------------------------
    // Busy counter
    // ------------------------------------------------------------------------
    multiplier_busy_counter u_busy (
        .mclk       (mclk),
        .rstn       (rstn),
        .load       (mult_end && (busy_after(seq_class) != `BUSY_NONE)),
        .load_value (busy_after(seq_class)),
        .count      (busy_count),
        .busy       (busy_now)
    );

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always @* begin
        stage_wait     = 1'b0;
        ma_bus         = 1'b0;
        mult_end       = 1'b0;
        seq_free       = 1'b0;
        next_seq_state = seq_state;
        next_seq_class = seq_class;
        case (seq_state)
            `SEQ_IDLE: begin
                seq_free = 1'b1;
            end
            `SEQ_MEM: begin
                ma_bus   = 1'b1;
                seq_free = 1'b1;
            end
            `SEQ_FIRST: begin
                // First access stage takes the bus
                ma_bus         = 1'b1;
                next_seq_state = `SEQ_MULT;
            end
            `SEQ_MULT: begin
                // Wait on nonzero counter
                // Word multiply results never block a double-length feed
                stage_wait = busy_now && !gap_ok &&
                             !(is_double_length(seq_class) && last_word);
                if (!stage_wait) begin
                    ma_bus   = 1'b1;
                    mult_end = 1'b1;
                    seq_free = 1'b1;
                end
            end
            default: begin
                next_seq_state = `SEQ_IDLE;
            end
        endcase
        if (seq_free) begin
            next_seq_state = `SEQ_IDLE;
            if (ex_valid) begin
                next_seq_class = ex_class;
                if (is_double_length(ex_class) ||
                    (ex_class == `CLASS_LONG_MULTIPLY_ACCUMULATE)) begin
                    next_seq_state = `SEQ_FIRST;
                end else if (uses_multiplier(ex_class)) begin
                    next_seq_state = `SEQ_MULT;
                end else if (ex_memory) begin
                    next_seq_state = `SEQ_MEM;
                end
            end
        end
    end

    assign ex_move = ex_valid && seq_free;

    always @* begin
        next_ex_valid = ex_valid;
        if (ex_move) begin
            next_ex_valid = 1'b0;
        end
        if (id_accept) begin
            next_ex_valid = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always @(posedge mclk) begin
        if (!rstn) begin
            ex_valid    <= 1'b0;
            ex_class    <= `CLASS_OTHER;
            ex_memory   <= 1'b0;
            seq_state   <= `SEQ_IDLE;
            seq_class   <= `CLASS_OTHER;
            gap         <= `GAP_CLEAR;
            last_double <= 1'b0;
            last_word   <= 1'b0;
        end else begin
            ex_valid  <= next_ex_valid;
            seq_state <= next_seq_state;
            seq_class <= next_seq_class;
            if (id_accept) begin
                ex_class  <= id_class;
                ex_memory <= id_memory;
            end
            // Owner of the busy count, not the follower, decides contention
            if (mult_end && (busy_after(seq_class) != `BUSY_NONE)) begin
                last_double <= is_double_length(seq_class);
                last_word   <= (seq_class == `CLASS_SIGNED_WORD_MULTIPLY);
            end
            if (id_accept) begin
                if (uses_multiplier(id_class)) begin
                    gap         <= 2'h0;
                end else if (gap != `GAP_CLEAR) begin
                    gap <= gap + 2'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Decode hold is conservative: it waits for an idle sequencer, which costs
    // a slot behind plain memory stages but keeps the execute latch from overflowing
    always @(posedge mclk) begin
        if (!rstn) begin
            id_hold         <= 1'b0;
            ma_bus_grant    <= 1'b0;
            if_bus_grant    <= 1'b0;
            slot_split      <= 1'b0;
            ma_stretch      <= 1'b0;
            mult_start      <= 1'b0;
            mult_busy       <= 1'b0;
            mult_contention <= 1'b0;
        end else begin
            id_hold      <= (id_accept && is_double_length(id_class)) ||
                            (next_ex_valid && (next_seq_state != `SEQ_IDLE));
            ma_bus_grant <= ma_bus;
            // Access first, fetch in the split half
            if_bus_grant <= if_request && !ma_bus;
            slot_split   <= if_request && ma_bus;
            ma_stretch   <= stage_wait;
            mult_start   <= mult_end && (busy_after(seq_class) != `BUSY_NONE);
            mult_busy    <= busy_now;
            mult_contention <= stage_wait && last_double;
        end
    end

endmodule
`default_nettype wire

// [testbench/multiplier_contention_interlock_props.sv]
// Port assertions for the multiplier contention interlock.
// Assumes a bind from the bench top and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "mult_interlock_regs.vh"

module multiplier_contention_interlock_props (
    input wire logic                mclk,
    input wire logic                rstn,
    input wire logic                id_valid,
    input wire logic [`CLASS_W-1:0] id_class,
    input wire logic                if_request,
    input wire logic                id_hold,
    input wire logic                ma_bus_grant,
    input wire logic                if_bus_grant,
    input wire logic                slot_split,
    input wire logic                ma_stretch,
    input wire logic                mult_start,
    input wire logic                mult_busy,
    input wire logic                mult_contention
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic dl_taken;
    assign dl_taken = id_valid && !id_hold && (id_class == `CLASS_SIGNED_DOUBLE_LENGTH
        || id_class == `CLASS_UNSIGNED_DOUBLE_LENGTH || id_class == `CLASS_LONG_PRODUCT_MULTIPLY);

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    // one slot hold
    chk_dl_hold: assert property (dl_taken |=> id_hold)
        else $error("decode not held after double-length multiply");
    chk_split_grant: assert property (slot_split |-> ma_bus_grant && !if_bus_grant)
        else $error("split slot without access grant");
    chk_split_cause: assert property (slot_split |-> $past(if_request))
        else $error("split slot without fetch request");
    chk_grant_exclusive: assert property (!(ma_bus_grant && if_bus_grant))
        else $error("fetch and access granted together");
    chk_fetch_cause: assert property (if_bus_grant |-> $past(if_request) && !ma_bus_grant)
        else $error("fetch grant without request");
    chk_stretch_busy: assert property (ma_stretch |-> mult_busy)
        else $error("stretch while multiplier idle");
    chk_contention_stretch: assert property (mult_contention |-> ma_stretch)
        else $error("contention flagged without stretch");
    chk_stretch_end: assert property ($fell(ma_stretch) |-> ma_bus_grant)
        else $error("stretched stage never ended");

    cov_dl: cover property (dl_taken);
    cov_stretch: cover property (ma_stretch);
    cov_split: cover property (slot_split);
endmodule
`default_nettype wire

// [testbench/multiplier_contention_interlock_tb.sv]
// Self-checking bench for the multiplier contention interlock.
// Assumes the design header on the include path; bench drives all ports.
`timescale 1ns/1ps
`default_nettype none
`include "mult_interlock_regs.vh"

module multiplier_contention_interlock_tb;
    logic                mclk, rstn, id_valid, id_memory, if_request;
    logic [`CLASS_W-1:0] id_class;
    logic                id_hold, ma_bus_grant, if_bus_grant, slot_split;
    logic                ma_stretch, mult_start, mult_busy, mult_contention;
    int                  n_mismatch, n_compared, cyc, t_last, t_prev;
    int                  n_st, n_busy, n_str, n_spl, n_cont, n_ma, n_if;

    multiplier_contention_interlock dut (.mclk, .rstn, .id_valid, .id_class, .id_memory, .if_request,
        .id_hold, .ma_bus_grant, .if_bus_grant, .slot_split, .ma_stretch, .mult_start, .mult_busy,
        .mult_contention);

    initial mclk = 1'b0;
    always #25 mclk = ~mclk;

    // -------------------------------------------------------------------------
    // Event counting, offset from the edge so clearing never races it
    // -------------------------------------------------------------------------
    always @(posedge mclk) begin
        #5;
        cyc++;
        if (mult_start === 1'b1) begin
            n_st++;
            t_prev = t_last;
            t_last = cyc;
        end
        if (mult_busy === 1'b1) n_busy++;
        if (ma_stretch === 1'b1) n_str++;
        if (slot_split === 1'b1) n_spl++;
        if (mult_contention === 1'b1) n_cont++;
        if (ma_bus_grant === 1'b1) n_ma++;
        if (if_bus_grant === 1'b1) n_if++;
    end

    // -------------------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Holds the request until an edge takes it; bounded wait on the hold
    task automatic issue(input logic [3:0] cls);
        int k;
        k = 0;
        id_valid = 1'b1;
        id_class = cls;
        while (id_hold !== 1'b0 && k < 50) begin
            @(negedge mclk);
            k++;
        end
        check("decode taken", k < 50, 1);
        @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic idle(input int n);
        id_valid = 1'b0;
        id_class = `CLASS_OTHER;
        repeat (n) @(negedge mclk);
    endtask

    task automatic clr();
        {n_st, n_busy, n_str, n_spl, n_cont, n_ma, n_if, t_last, t_prev} = '0;
    endtask

    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    task automatic t_double(input logic fetch);
        logic [3:0] dl [3] = '{`CLASS_SIGNED_DOUBLE_LENGTH, `CLASS_UNSIGNED_DOUBLE_LENGTH,
                               `CLASS_LONG_PRODUCT_MULTIPLY};
        foreach (dl[i]) begin
            clr();
            if_request = fetch;
            issue(dl[i]);
            check("id_hold", id_hold, 1);
            issue(`CLASS_OTHER);
            idle(14);
            if_request = 1'b0;
            check("busy cycles", n_busy, 4);
            check("starts", n_st, 1);
            check("access stages", n_ma, 2);
            check("contention", n_cont, 0);
            check("splits", n_spl, fetch ? 2 : 0);
            check("fetch grants", n_if > 0, fetch);
        end
        $display("double-length test done");
    endtask

    task automatic t_word_users();
        logic [3:0] u [4] = '{`CLASS_ACC_STORE_TO_REGISTER, `CLASS_ACC_STORE_TO_MEMORY,
                              `CLASS_ACC_LOAD_FROM_REGISTER, `CLASS_ACC_LOAD_FROM_MEMORY};
        foreach (u[i]) begin
            clr();
            if_request = 1'b1;
            issue(`CLASS_SIGNED_WORD_MULTIPLY);
            issue(u[i]);
            idle(12);
            if_request = 1'b0;
            check("starts", n_st, 1);
            check("stretch cycles", n_str, 2);
            check("split seen", n_spl > 0, 1);
        end
        $display("word multiply test done");
    endtask

    task automatic t_contention();
        logic [3:0] u [8] = '{4'h5, 4'h6, 4'h2, 4'h1, 4'h7, 4'h8, 4'h9, 4'hA};
        foreach (u[i]) begin
            clr();
            issue(`CLASS_SIGNED_DOUBLE_LENGTH);
            issue(u[i]);
            idle(16);
            check("contention", n_cont > 0, 1);
            check("starts", n_st, (u[i] < 4'h7) ? 2 : 1);
        end
        $display("contention test done");
    endtask

    task automatic t_gap();
        clr();
        id_memory = 1'b1;
        issue(`CLASS_UNSIGNED_DOUBLE_LENGTH);
        issue(`CLASS_OTHER);
        issue(`CLASS_OTHER);
        id_memory = 1'b0;
        issue(`CLASS_LONG_MULTIPLY_ACCUMULATE);
        idle(16);
        check("stretch", n_str, 0);
        check("contention", n_cont, 0);
        $display("gap test done");
    endtask

    // -------------------------------------------------------------------------
    // Main sequence and watchdog
    // -------------------------------------------------------------------------
    initial begin
        {rstn, id_valid, id_memory, if_request, id_class} = '0;
        repeat (4) @(negedge mclk);
        check("reset outputs", {id_hold, ma_bus_grant, if_bus_grant, slot_split,
            ma_stretch, mult_start, mult_busy, mult_contention}, 0);
        rstn = 1'b1;
        t_double(1'b0);
        t_double(1'b1);
        t_word_users();
        t_contention();
        t_gap();
        complete_run();
    end

    // Whole run is well under a thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule

bind multiplier_contention_interlock multiplier_contention_interlock_props props_i (.mclk, .rstn,
    .id_valid, .id_class, .if_request, .id_hold, .ma_bus_grant, .if_bus_grant, .slot_split,
    .ma_stretch, .mult_start, .mult_busy, .mult_contention);
`default_nettype wire
